/* File: verilog/tone_params.svh */
/*
 * offsets, field positions, reset values and counts of the tone generator
 * control block; assumes inclusion by bare name from design files.
 */
`ifndef TONE_PARAMS_SVH
`define TONE_PARAMS_SVH

// ----------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------
`define HIGH_DIV_INDEX 8'h11
`define LOW_DIV_INDEX 8'h12
`define CTL_INDEX 8'h13
`define HIGH_DIV_ADDR 8'h44
`define LOW_DIV_ADDR 8'h48
`define CTL_ADDR 8'h4C
`define ADDR_W 8

// ----------------------------------------------------------------
// control register fields and reset values
// ----------------------------------------------------------------
`define CTL_MELODY_EN_BIT 0
`define CTL_DIV_SEL_BIT 1
`define CTL_CLK_EN_BIT 2
`define CTL_W 3
`define CTL_RESET 3'h0
`define DIVISOR_RESET 8'h00
`define LATCH_RESET 1'h1

// ----------------------------------------------------------------
// synthesizer counts
// ----------------------------------------------------------------
`define STEPS_PER_PERIOD 5'h17
`define STEPS_HIGH 5'h0C
`define STEP_W 5

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: verilog/tone_pkg.sv */
/*
 * types shared by the tone generator control files;
 * assumes nothing of its surroundings.
 */
package tone_pkg;
    typedef enum logic [1:0] {
        PH0 = 2'b00,
        PH1 = 2'b01,
        PH2 = 2'b10
    } div_phase_e;

    typedef logic [1:0] resp_t;
endpackage

/* File: verilog/tone_synth_if.sv */
/*
 * link between the control block and one square synthesizer;
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface tone_synth_if #(parameter int DIV_W = 8);
    logic tick;
    logic [DIV_W-1:0] divisor;
    logic wave;
    modport ctrl(output tick, output divisor, input wave);
    modport synth(input tick, input divisor, output wave);
endinterface

/* File: verilog/tone_square_synth.sv */
/*
 * one square wave synthesizer: period 23 x (divisor + 2) ticks,
 * high for 12 of 23 steps; assumes tick is a one-cycle enable.
 */
`timescale 1ns/1ps
`include "tone_params.svh"
module tone_square_synth #(
    parameter int DIV_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    tone_synth_if.synth sif
);
    import tone_pkg::*;

    logic [DIV_W:0] prescale;
    logic [`STEP_W-1:0] step;
    wire logic [DIV_W:0] pre_last;
    wire logic running;
    wire logic pre_wrap;

    // ----------------------------------------------------------------
    // counters
    // ----------------------------------------------------------------
    assign running = sif.divisor != '0; // [RL15]
    assign pre_last = {1'b0, sif.divisor} + (DIV_W+1)'(1); // [RL14]
    assign pre_wrap = prescale >= pre_last;
    assign sif.wave = running && (step < `STEPS_HIGH); // [RL16]

    always_ff @(posedge aclk) begin
        if (!aresetn || !running) begin
            prescale <= '0;
            step <= '0;
        end else if (sif.tick) begin
            prescale <= pre_wrap ? '0 : prescale + (DIV_W+1)'(1);
            if (pre_wrap) begin
                step <= (step == `STEPS_PER_PERIOD - 5'h01) ? '0 :
                        step + 5'h01; // [RL14]
            end
        end
    end

    a_synth_stopped: assert property ( // [RL15]
        @(posedge aclk) disable iff (!aresetn)
        sif.divisor == '0 |-> !sif.wave ##1 step == '0)
        else $error("stopped synthesizer still running");
    a_step_bound: assert property ( // [RL14]
        @(posedge aclk) disable iff (!aresetn)
        step < `STEPS_PER_PERIOD)
        else $error("step count out of range");
endmodule

/* File: verilog/tone_generator_control.sv */
/*
 * tone generator control: frequency and control registers over
 * AXI4-Lite, tone clock divider, two square synthesizers and the
 * two shared port pins; assumes one clock and synchronous inputs.
 */
`timescale 1ns/1ps
`include "tone_params.svh"
// Behaviour
// [RL1] tone clock full rate or one third
// [RL2] tone output floats when nothing selected
// [RL3] write-only high and low divisor registers
// [RL4] control register readable, bits 7..3 zero
// [RL5] control bit 2 routes tone clock
// [RL6] port access kept on tone clock pin
// [RL7] software keeps tone clock latch high
// [RL8] control bit 0 routes melody wave
// [RL9] port access kept on melody pin
// [RL10] software keeps melody latch high
// [RL11] zero high divisor drives melody high
// [RL12] semitone notes as tone or square
// [RL13] twelve modem frequencies on tone output
// [RL14] frequency is clock over 23(x+2)
// [RL15] zero divisor stops its synthesizer
// [RL16] melody duty 12/23, divisor down to 2
// [RL17] enabled pin carries selected tone clock
// [RL18] reset clears divisors and control bits
module tone_generator_control #(
    parameter int DIV_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output tone_pkg::resp_t s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output tone_pkg::resp_t s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [1:0] tone_out,
    output logic tone_oe_n,
    input wire logic tone_clock_pin_in,
    output logic tone_clock_pin_out,
    output logic tone_clock_pin_oe_n,
    input wire logic tone_clock_port_write,
    input wire logic tone_clock_port_wdata,
    output logic tone_clock_port_latch,
    output logic tone_clock_pin_state,
    input wire logic melody_pin_in,
    output logic melody_pin_out,
    output logic melody_pin_oe_n,
    input wire logic melody_port_write,
    input wire logic melody_port_wdata,
    output logic melody_port_latch,
    output logic melody_pin_state
);
    import tone_pkg::*;

    if (DIV_W != 8) begin : g_width_check
        $error("divisor width must be 8");
    end

    // ----------------------------------------------------------------
    // register bus slave
    // ----------------------------------------------------------------
    logic [DIV_W-1:0] high_group_divisor;
    logic [DIV_W-1:0] low_group_divisor;
    logic [`CTL_W-1:0] clock_melody_control;
    logic aw_held;
    logic w_held;
    logic [`ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;
    logic [`ADDR_W-1:0] rd_addr;
    wire logic aw_take;
    wire logic w_take;
    wire logic do_write;
    wire logic wr_high;
    wire logic wr_low;
    wire logic wr_ctl;
    wire logic wr_hit;
    wire logic rd_ctl;
    wire logic rd_hit;
    wire logic [31:0] next_rdata;

    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_high = aw_addr == `HIGH_DIV_ADDR;
    assign wr_low = aw_addr == `LOW_DIV_ADDR;
    assign wr_ctl = aw_addr == `CTL_ADDR;
    assign wr_hit = wr_high || wr_low || wr_ctl;
    assign rd_ctl = s_axi_araddr == `CTL_ADDR;
    assign rd_hit = rd_ctl || s_axi_araddr == `HIGH_DIV_ADDR ||
                    s_axi_araddr == `LOW_DIV_ADDR;
    assign next_rdata = rd_ctl ? {29'h0, clock_melody_control} :
                        32'h0; // [RL4] [RL3]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_byte <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_OKAY;
            rd_addr <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            rd_addr <= s_axi_araddr;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            high_group_divisor <= `DIVISOR_RESET; // [RL18]
            low_group_divisor <= `DIVISOR_RESET;
            clock_melody_control <= `CTL_RESET;
        end else if (do_write && w_lane0) begin
            if (wr_high) begin
                high_group_divisor <= w_byte; // [RL3]
            end
            if (wr_low) begin
                low_group_divisor <= w_byte; // [RL3]
            end
            if (wr_ctl) begin
                clock_melody_control <= w_byte[`CTL_W-1:0]; // [RL4]
            end
        end
    end

    wire logic melody_out_enable;
    wire logic tone_clock_divide_select;
    wire logic tone_clock_out_enable;
    assign melody_out_enable = clock_melody_control[`CTL_MELODY_EN_BIT];
    assign tone_clock_divide_select = clock_melody_control[`CTL_DIV_SEL_BIT];
    assign tone_clock_out_enable = clock_melody_control[`CTL_CLK_EN_BIT];

    // ----------------------------------------------------------------
    // tone clock divider
    // ----------------------------------------------------------------
    div_phase_e phase;
    div_phase_e next_phase;
    logic tone_clock_wave;
    wire logic tone_section_clock;

    always_comb begin
        case (phase)
            PH0: next_phase = PH1;
            PH1: next_phase = PH2;
            PH2: next_phase = PH0;
            default: next_phase = PH0;
        endcase
    end

    assign tone_section_clock = !tone_clock_divide_select ||
                                phase == PH0; // [RL1]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase <= PH0;
            tone_clock_wave <= 1'b0;
        end else begin
            phase <= tone_clock_divide_select ? next_phase : PH0;
            if (tone_section_clock) begin
                tone_clock_wave <= !tone_clock_wave; // [RL17]
            end
        end
    end

    // ----------------------------------------------------------------
    // synthesizers
    // ----------------------------------------------------------------
    tone_synth_if #(.DIV_W(DIV_W)) sif [2] ();
    wire logic [DIV_W-1:0] divisors [2];
    assign divisors[0] = high_group_divisor;
    assign divisors[1] = low_group_divisor;

    for (genvar g = 0; g < 2; g++) begin : g_synth
        assign sif[g].tick = tone_section_clock;
        assign sif[g].divisor = divisors[g];
        tone_square_synth #(.DIV_W(DIV_W)) u_synth (
            .aclk(aclk),
            .aresetn(aresetn),
            .sif(sif[g])
        ); // [RL12] [RL13]
    end

    wire logic tone_active;
    wire logic melody_wave;
    assign tone_active = high_group_divisor != '0 ||
                         low_group_divisor != '0; // [RL15]
    assign melody_wave = high_group_divisor == '0 ? 1'b1 :
                         sif[0].wave; // [RL11] [RL16]

    // ----------------------------------------------------------------
    // tone output and shared port pins
    // ----------------------------------------------------------------
    wire logic next_clock_pin;
    wire logic next_melody_pin;
    assign next_clock_pin = tone_clock_port_latch &&
        (!tone_clock_out_enable || tone_clock_wave); // [RL5]
    assign next_melody_pin = melody_port_latch &&
        (!melody_out_enable || melody_wave); // [RL8]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tone_out <= 2'h0;
            tone_oe_n <= 1'b1;
            tone_clock_pin_out <= 1'b1;
            tone_clock_pin_oe_n <= 1'b1;
            melody_pin_out <= 1'b1;
            melody_pin_oe_n <= 1'b1;
        end else begin
            tone_out <= {sif[0].wave, sif[1].wave};
            tone_oe_n <= !tone_active; // [RL2]
            tone_clock_pin_out <= next_clock_pin;
            tone_clock_pin_oe_n <= next_clock_pin;
            melody_pin_out <= next_melody_pin;
            melody_pin_oe_n <= next_melody_pin;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tone_clock_port_latch <= `LATCH_RESET;
            melody_port_latch <= `LATCH_RESET;
            tone_clock_pin_state <= 1'b1;
            melody_pin_state <= 1'b1;
        end else begin
            if (tone_clock_port_write) begin
                tone_clock_port_latch <= tone_clock_port_wdata; // [RL6]
            end
            if (melody_port_write) begin
                melody_port_latch <= melody_port_wdata; // [RL9]
            end
            tone_clock_pin_state <= tone_clock_pin_in; // [RL6]
            melody_pin_state <= melody_pin_in; // [RL9]
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_full_rate: assert property ( // [RL1]
        !tone_clock_divide_select |-> tone_section_clock)
        else $error("tone clock not at full rate");
    a_third_rate: assert property ( // [RL1]
        tone_section_clock && tone_clock_divide_select ##1
        tone_clock_divide_select |-> !tone_section_clock ##1
        (!tone_clock_divide_select || !tone_section_clock))
        else $error("tone clock not divided by three");
    a_tone_float: assert property ( // [RL2]
        !tone_active |=> tone_oe_n)
        else $error("tone output driven while idle");
    a_ctl_upper_zero: assert property ( // [RL4]
        s_axi_rvalid && rd_addr == `CTL_ADDR |-> s_axi_rdata[31:3] == '0)
        else $error("control upper bits not zero");
    a_clock_pin_port: assert property ( // [RL5]
        !tone_clock_out_enable |=> tone_clock_pin_out ==
        $past(tone_clock_port_latch))
        else $error("tone clock pin not a port line");
    a_latch_write: assert property ( // [RL6]
        tone_clock_port_write |=> tone_clock_port_latch ==
        $past(tone_clock_port_wdata))
        else $error("tone clock latch not written");
    a_melody_port: assert property ( // [RL8]
        !melody_out_enable |=> melody_pin_out == $past(melody_port_latch))
        else $error("melody pin not a port line");
    a_melody_high: assert property ( // [RL11]
        melody_out_enable && high_group_divisor == '0 &&
        melody_port_latch |=> melody_pin_out && melody_pin_oe_n)
        else $error("melody pin not high for zero divisor");
    a_reset_clear: assert property ( // [RL18]
        @(posedge aclk) disable iff (1'b0)
        !aresetn |=> clock_melody_control == '0 &&
        high_group_divisor == '0 && low_group_divisor == '0)
        else $error("registers not cleared by reset");
    a_write_answer: assert property ( // [RL3]
        aw_held && w_held && !s_axi_bvalid |=> s_axi_bvalid)
        else $error("write response missing");
endmodule

/* File: test/tone_generator_control_test.sv */
/*
 * self-checking bench for tone_generator_control: registers, tone clock,
 * melody wave and port pins; assumes tone_params.svh on the include path.
 */
`timescale 1ns/1ps
`include "tone_params.svh"
module tone_generator_control_test;
    import tone_pkg::*;
    // ----------------------------------------------------------------
    // stimulus and wiring
    // ----------------------------------------------------------------
    logic aclk = 0, aresetn = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [31:0] s_axi_rdata;
    resp_t s_axi_bresp, s_axi_rresp, r;
    logic [1:0] tone_out;
    logic tone_oe_n, tc_out, tc_oe_n, tc_latch, tc_state;
    logic md_out, md_oe_n, md_latch, md_state;
    logic tc_wr = 0, tc_wd = 1, md_wr = 0, md_wd = 1;
    wire logic tc_in = tc_oe_n;
    wire logic md_in = md_oe_n;
    logic [31:0] d;
    int err_count = 0, n_compared = 0, cycles = 0, hi, lo;

    always #25 aclk = ~aclk;

    tone_generator_control #(.DIV_W(8)) uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .tone_out(tone_out),
        .tone_oe_n(tone_oe_n), .tone_clock_pin_in(tc_in),
        .tone_clock_pin_out(tc_out), .tone_clock_pin_oe_n(tc_oe_n),
        .tone_clock_port_write(tc_wr), .tone_clock_port_wdata(tc_wd),
        .tone_clock_port_latch(tc_latch), .tone_clock_pin_state(tc_state),
        .melody_pin_in(md_in), .melody_pin_out(md_out),
        .melody_pin_oe_n(md_oe_n), .melody_port_write(md_wr),
        .melody_port_wdata(md_wd), .melody_port_latch(md_latch),
        .melody_pin_state(md_state)
    );

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] v);
        logic aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1;
                s_axi_awvalid <= 0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1;
                s_axi_wvalid <= 0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 0;
        @(posedge aclk);
    endtask

    task automatic axi_read(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
        @(posedge aclk);
    endtask

    // widths of one high and one low run on a pin (1 melody, 0 clock)
    task automatic run_len(input bit mel);
        hi = 0;
        lo = 0;
        do @(posedge aclk); while ((mel ? md_out : tc_out) !== 1'b0);
        do @(posedge aclk); while ((mel ? md_out : tc_out) !== 1'b1);
        while ((mel ? md_out : tc_out) === 1'b1 && hi < 400) begin
            hi++;
            @(posedge aclk);
        end
        while ((mel ? md_out : tc_out) === 1'b0 && lo < 400) begin
            lo++;
            @(posedge aclk);
        end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_reset;
        axi_read(`CTL_ADDR);
        check(d, 32'h0);
        check(tone_oe_n, 1'b1);
        check({tc_latch, md_latch, tc_out, md_out}, 4'hF);
        $display("test_reset done");
    endtask

    task automatic test_regs;
        axi_write(`CTL_ADDR, 32'h0000_00FF);
        check(r, `RESP_OKAY);
        axi_read(`CTL_ADDR);
        check(d, 32'h0000_0007);
        axi_write(`HIGH_DIV_ADDR, 32'h0000_007F);
        axi_read(`HIGH_DIV_ADDR);
        check(d, 32'h0);
        axi_read(8'h50);
        check(r, `RESP_SLVERR);
        axi_write(8'h50, 32'h0000_0001);
        check(r, `RESP_SLVERR);
        axi_write(`CTL_ADDR, 32'h0);
        $display("test_regs done");
    endtask

    task automatic test_melody;
        axi_write(`HIGH_DIV_ADDR, 32'h0);
        axi_write(`LOW_DIV_ADDR, 32'h0);
        axi_write(`CTL_ADDR, 32'h0000_0001);
        hi = 0;
        repeat (40) begin
            @(posedge aclk);
            if (md_out !== 1'b1 || tone_out !== 2'h0) hi++;
        end
        check(hi, 0);
        check(tone_oe_n, 1'b1);
        axi_write(`HIGH_DIV_ADDR, 32'h0000_0002);
        run_len(1);
        check({hi[15:0], lo[15:0]}, {16'd48, 16'd44});
        check(tone_oe_n, 1'b0);
        axi_write(`CTL_ADDR, 32'h0000_0003);
        run_len(1);
        check({hi[15:0], lo[15:0]}, {16'd144, 16'd132});
        axi_write(`CTL_ADDR, 32'h0);
        repeat (3) @(posedge aclk);
        hi = 0;
        repeat (100) begin
            @(posedge aclk);
            if (md_out !== 1'b1) hi++;
        end
        check(hi, 0);
        $display("test_melody done");
    endtask

    task automatic test_clock;
        axi_write(`CTL_ADDR, 32'h0000_0004);
        run_len(0);
        check({hi[15:0], lo[15:0]}, {16'd1, 16'd1});
        axi_write(`CTL_ADDR, 32'h0000_0006);
        run_len(0);
        check({hi[15:0], lo[15:0]}, {16'd3, 16'd3});
        axi_write(`CTL_ADDR, 32'h0);
        repeat (3) @(posedge aclk);
        hi = 0;
        repeat (20) begin
            @(posedge aclk);
            if (tc_out !== 1'b1) hi++;
        end
        check(hi, 0);
        $display("test_clock done");
    endtask

    task automatic test_port;
        logic [1:0] seen;
        int bad;
        bad = 0;
        tc_wr <= 1;
        tc_wd <= 0;
        md_wr <= 1;
        md_wd <= 0;
        @(posedge aclk);
        tc_wr <= 0;
        md_wr <= 0;
        repeat (4) @(posedge aclk);
        check({tc_latch, md_latch}, 2'b00);
        check({tc_out, md_out, tc_oe_n, md_oe_n}, 4'h0);
        check({tc_state, md_state}, 2'b00);
        tc_wr <= 1;
        tc_wd <= 1;
        md_wr <= 1;
        md_wd <= 1;
        @(posedge aclk);
        tc_wr <= 0;
        md_wr <= 0;
        axi_write(`HIGH_DIV_ADDR, 32'h0000_0002);
        axi_write(`CTL_ADDR, 32'h0000_0005);
        tc_wr <= 1;
        md_wr <= 1;
        @(posedge aclk);
        tc_wr <= 0;
        md_wr <= 0;
        repeat (100) begin
            seen = {tc_out, md_out};
            @(posedge aclk);
            if ({tc_state, md_state} !== seen) bad++;
        end
        check(bad, 0);
        check({tc_latch, md_latch}, 2'b11);
        axi_write(`CTL_ADDR, 32'h0);
        $display("test_port done");
    endtask

    // ----------------------------------------------------------------
    // run control
    // ----------------------------------------------------------------
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        test_reset();
        test_regs();
        test_melody();
        test_clock();
        test_port();
        complete_run();
    end
endmodule
